// [src/pdoe_pkg.sv]
// package: register map, field masks and reset values for the port drive block
package pdoe_pkg;

    // ************************************************************
    // bus widths
    // ************************************************************
    localparam int ADDR_W = 8;                      // csiop offset width
    localparam int DATA_W = 8;                      // register data width
    localparam int NUM_PORTS = 4;                   // ports a, b, c, d

    // ************************************************************
    // register offsets from the control-register base
    // ************************************************************
    localparam logic [7:0] OFS_PORT_A_DRIVER_TYPE = 8'h08;
    localparam logic [7:0] OFS_PORT_B_DRIVER_TYPE = 8'h09;
    localparam logic [7:0] OFS_PORT_A_OE_STATUS = 8'h0c;
    localparam logic [7:0] OFS_PORT_B_OE_STATUS = 8'h0d;
    localparam logic [7:0] OFS_PORT_C_DRIVER_TYPE = 8'h16;
    localparam logic [7:0] OFS_PORT_D_DRIVER_TYPE = 8'h17;
    localparam logic [7:0] OFS_PORT_C_OE_STATUS = 8'h1a;
    localparam logic [7:0] OFS_PORT_D_OE_STATUS = 8'h1b;

    // ************************************************************
    // field masks: which bits mean open drain, which mean fast slew
    // ************************************************************
    localparam logic [7:0] OD_MASK_A = 8'hf0;       // pins 7..4
    localparam logic [7:0] SLEW_MASK_A = 8'h0f;     // pins 3..0
    localparam logic [7:0] OD_MASK_B = 8'hf0;
    localparam logic [7:0] SLEW_MASK_B = 8'h0f;
    localparam logic [7:0] OD_MASK_C = 8'h9c;       // pins 7,4,3,2
    localparam logic [7:0] SLEW_MASK_C = 8'h00;
    localparam logic [7:0] OD_MASK_D = 8'h00;
    localparam logic [7:0] SLEW_MASK_D = 8'h06;     // pins 2,1
    localparam logic [7:0] PIN_MASK_A = 8'hff;      // implemented pins per port
    localparam logic [7:0] PIN_MASK_B = 8'hff;
    localparam logic [7:0] PIN_MASK_C = 8'h9c;
    localparam logic [7:0] PIN_MASK_D = 8'h06;

    // ************************************************************
    // reset values and output-enable source selection
    // ************************************************************
    localparam logic [7:0] DRIVER_TYPE_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // source of the final output enable for a pin
    typedef enum logic [1:0] {
        PDOE_SRC_DIR,                               // direction register bit
        PDOE_SRC_PT,                                // logic-array product term
        PDOE_SRC_PIO                                // peripheral i/o repeater, port a only
    } pdoe_src_t;

endpackage : pdoe_pkg

// [src/pdoe_cfg_if.sv]
// interface: per-port drive configuration handed from the register file to the pad drivers
interface pdoe_cfg_if;
    import pdoe_pkg::*;

    logic [7:0] open_drain;                         // 1 = pull low only
    logic [7:0] fast_slew;                          // 1 = fast edges
    logic [7:0] final_oe;                           // merged enable seen by the driver

    modport regs (output open_drain, output fast_slew, input final_oe);
    modport pads (input open_drain, input fast_slew, output final_oe);
endinterface : pdoe_cfg_if

// [src/pdoe_oe_mux.sv]
// module: output-enable source select for one port
module pdoe_oe_mux
    import pdoe_pkg::*;
#(
    parameter logic [7:0] PIN_MASK = 8'hff,         // implemented pins
    parameter bit HAS_PIO = 1'b0                    // repeater exists on this port
) (
    input wire logic [7:0] dir_bits,
    input wire logic [7:0] pt_oe,
    input wire logic pio_oe,
    input wire pdoe_src_t [7:0] src_sel,
    pdoe_cfg_if.pads cfg
);
    // ************************************************************
    // per-pin selection
    // ************************************************************
    logic [7:0] sel_oe;                             // raw selected enable per pin

    // each pin picks one of three sources; pio falls back to direction when absent
    for (genvar i = 0; i < 8; i++) begin : g_pin
        assign sel_oe[i] = (src_sel[i] == PDOE_SRC_PT) ? pt_oe[i] :
                           (src_sel[i] == PDOE_SRC_PIO && HAS_PIO) ? pio_oe :
                           dir_bits[i];
    end

    // missing pins never report as enabled
    assign cfg.final_oe = sel_oe & PIN_MASK;
endmodule : pdoe_oe_mux

// [src/pdoe_pad_drive.sv]
// module: pad driver control for one port: open drain, slew and output enable
module pdoe_pad_drive (
    input wire logic [7:0] data_out,
    pdoe_cfg_if.pads cfg,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_fast
);
    // ************************************************************
    // drive type
    // ************************************************************
    // open drain only ever drives a low; a high leaves the pin to the pull-up
    assign pad_out = data_out & ~cfg.open_drain;
    assign pad_oe = cfg.final_oe & ~(cfg.open_drain & data_out);
    assign pad_fast = cfg.fast_slew;
endmodule : pdoe_pad_drive

// [src/pdoe_top.sv]
// top: drive-type registers, output-enable status and pad control for four ports
//
// Functional notes
// - open-drain bit set: pull low only
// - slew bit set: fast slew rate
// - bit clear: push-pull, normal slew
// - drive-select registers reset to zero
// - port a: 7..4 open drain, 3..0 slew
// - port b: same layout as port a
// - port c: open drain on 7,4,3,2 only
// - port d: slew on bits 2,1 only
// - status reads show current final enable
// - status bit 1 output, 0 input
// - enable from term, direction or repeater
// - port a status bit n is pin n
// - port b status bit n is pin n
// - port c status bits 7,4,3,2 only
// - port d status bits 2,1 only
module pdoe_top
    import pdoe_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [pdoe_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pdoe_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pdoe_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [31:0] dir_bits,
    input wire logic [31:0] pt_oe,
    input wire logic pio_oe,
    input wire logic [63:0] src_sel,
    input wire logic [31:0] data_out,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe,
    output logic [31:0] pad_fast
);
    import pdoe_pkg::*;

    // ************************************************************
    // per-port tables
    // ************************************************************
    localparam logic [31:0] OD_MASKS = {OD_MASK_D, OD_MASK_C, OD_MASK_B, OD_MASK_A};
    localparam logic [31:0] SLEW_MASKS = {SLEW_MASK_D, SLEW_MASK_C, SLEW_MASK_B, SLEW_MASK_A};
    localparam logic [31:0] PIN_MASKS = {PIN_MASK_D, PIN_MASK_C, PIN_MASK_B, PIN_MASK_A};
    localparam logic [31:0] DRV_OFS = {OFS_PORT_D_DRIVER_TYPE, OFS_PORT_C_DRIVER_TYPE,
                                       OFS_PORT_B_DRIVER_TYPE, OFS_PORT_A_DRIVER_TYPE};
    localparam logic [31:0] STS_OFS = {OFS_PORT_D_OE_STATUS, OFS_PORT_C_OE_STATUS,
                                       OFS_PORT_B_OE_STATUS, OFS_PORT_A_OE_STATUS};

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] drv_reg [NUM_PORTS];                // driver-type registers, stored masked
    logic [7:0] rdata_reg;                          // registered read data
    logic [31:0] pad_out_reg;
    logic [31:0] pad_oe_reg;
    logic [31:0] pad_fast_reg;
    logic [31:0] oe_all;                            // merged final enables, all ports
    logic [31:0] pout_all;
    logic [31:0] poe_all;
    logic [31:0] pfast_all;
    logic [NUM_PORTS-1:0] drv_hit;                  // address decodes
    logic [NUM_PORTS-1:0] sts_hit;
    logic [7:0] rd_mux;

    // ************************************************************
    // per-port datapath
    // ************************************************************
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        pdoe_cfg_if cfg ();
        logic [7:0] od_mask;
        logic [7:0] sl_mask;
        pdoe_src_t [7:0] pin_src;                   // per-pin source, all from the port's field

        // every pin of a port follows the one 2-bit field at the bottom of its slice
        for (genvar n = 0; n < 8; n++) begin : g_src
            assign pin_src[n] = pdoe_src_t'(src_sel[p*16 +: 2]);
        end

        assign od_mask = OD_MASKS[p*8 +: 8];
        assign sl_mask = SLEW_MASKS[p*8 +: 8];
        // bits without the option have no effect on the pad
        assign cfg.open_drain = drv_reg[p] & od_mask;
        assign cfg.fast_slew = drv_reg[p] & sl_mask;
        assign drv_hit[p] = (reg_addr == DRV_OFS[p*8 +: 8]);
        assign sts_hit[p] = (reg_addr == STS_OFS[p*8 +: 8]);
        assign oe_all[p*8 +: 8] = cfg.final_oe;

        pdoe_oe_mux #(
            .PIN_MASK(PIN_MASKS[p*8 +: 8]),
            .HAS_PIO(p == 0)
        ) u_mux (
            .dir_bits(dir_bits[p*8 +: 8]),
            .pt_oe(pt_oe[p*8 +: 8]),
            .pio_oe(pio_oe),
            .src_sel(pin_src),
            .cfg(cfg)
        );

        pdoe_pad_drive u_pad (
            .data_out(data_out[p*8 +: 8]),
            .cfg(cfg),
            .pad_out(pout_all[p*8 +: 8]),
            .pad_oe(poe_all[p*8 +: 8]),
            .pad_fast(pfast_all[p*8 +: 8])
        );

        // driver-type register; only capable bits are stored so the rest read zero
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                drv_reg[p] <= DRIVER_TYPE_RESET;
            end else if (reg_wr && drv_hit[p]) begin
                drv_reg[p] <= reg_wdata & (od_mask | sl_mask);
            end
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    // status reads sample the live enable; writes to status offsets fall through
    always_comb begin
        rd_mux = ZERO_BYTE;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (drv_hit[p]) begin
                rd_mux = drv_reg[p];
            end
            if (sts_hit[p]) begin
                rd_mux = oe_all[p*8 +: 8];
            end
        end
    end

    // ************************************************************
    // output registers
    // ************************************************************
    // pads are registered so every top output comes from a flop
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_reg <= ZERO_BYTE;
            pad_out_reg <= '0;
            pad_oe_reg <= '0;
            pad_fast_reg <= '0;
        end else begin
            if (reg_rd) begin
                rdata_reg <= rd_mux;
            end
            pad_out_reg <= pout_all;
            pad_oe_reg <= poe_all;
            pad_fast_reg <= pfast_all;
        end
    end

    assign reg_rdata = rdata_reg;
    assign pad_out = pad_out_reg;
    assign pad_oe = pad_oe_reg;
    assign pad_fast = pad_fast_reg;
endmodule : pdoe_top

// [dv/pdoe_pin_model.sv]
// board side of the pins: a pull-up on every pad
module pdoe_pin_model (
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    output logic [31:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released pad floats up, so an open-drain high shows as 1
    assign pin_level = pad_out | ~pad_oe;
endmodule // pdoe_pin_model

// [dv/pdoe_top_checker.sv]
// checker: timing and value relations at the port drive block ports
module pdoe_top_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [31:0] dir_bits,
    input wire logic [31:0] pt_oe,
    input wire logic [63:0] src_sel,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_fast
);
    timeunit 1ns;
    timeprecision 1ps;
    // any of the eight mapped offsets
    wire logic hit = reg_addr inside {8'h08, 8'h09, 8'h0c, 8'h0d, 8'h16, 8'h17, 8'h1a, 8'h1b};
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);
    // ********
    // assertions
    // ********
    reset_zero_a: assert property (disable iff (1'b0)
        reset |-> pad_fast == '0 && reg_rdata == '0) else $error("outputs not clear in reset");
    slew_wr_a: assert property (reg_wr && reg_addr == 8'h08 |-> ##2
        pad_fast[3:0] == $past(reg_wdata[3:0], 2)) else $error("port a slew wrong");
    drain_wr_a: assert property (reg_wr && reg_addr == 8'h09 && reg_wdata[7] |-> ##2
        !pad_out[15]) else $error("open drain pin driven high");
    slew_d_a: assert property (reg_wr && reg_addr == 8'h17 |-> ##2
        pad_fast[26:25] == $past(reg_wdata[2:1], 2)) else $error("port d slew wrong");
    fast_mask_a: assert property ((pad_fast & 32'hf9fff0f0) == '0)
        else $error("fast slew on incapable pin");
    unmap_rd_a: assert property (reg_rd && !hit |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    c_unused_a: assert property (reg_rd && reg_addr inside {8'h16, 8'h1a} |=>
        (reg_rdata & 8'h63) == '0) else $error("port c unused bits set");
    d_unused_a: assert property (reg_rd && reg_addr inside {8'h17, 8'h1b} |=>
        (reg_rdata & 8'hf9) == '0) else $error("port d unused bits set");
    stat_dir_a: assert property (reg_rd && reg_addr == 8'h0c && src_sel[1:0] == 2'h0 |=>
        reg_rdata == $past(dir_bits[7:0])) else $error("port a enable status wrong");
    stat_pt_a: assert property (reg_rd && reg_addr == 8'h0d && src_sel[17:16] == 2'h1 |=>
        reg_rdata == $past(pt_oe[15:8])) else $error("port b enable status wrong");
endmodule // pdoe_top_checker

// [dv/tb_pdoe_top.sv]
// testbench: random register traffic with pad, pin and readback checks
module tb_pdoe_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pdoe_pkg::*;
    logic mclk = 1'b0, reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pio_oe = 1'b0;
    logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
    logic [31:0] dir_bits = '0, pt_oe = '0, data_out = '0, pad_out, pad_oe, pad_fast, pin_level;
    logic [63:0] src_sel = '0;
    int bad_count = 0, checked = 0, cycles = 0;
    integer seed = 32'h98d2b30c;
    // reference model: stored drive bytes and per-port masks
    logic [7:0] drv [4] = '{default: '0};
    logic [7:0] odm [4] = '{OD_MASK_A, OD_MASK_B, OD_MASK_C, OD_MASK_D};
    logic [7:0] slm [4] = '{SLEW_MASK_A, SLEW_MASK_B, SLEW_MASK_C, SLEW_MASK_D};
    logic [7:0] pm [4] = '{PIN_MASK_A, PIN_MASK_B, PIN_MASK_C, PIN_MASK_D};
    logic [7:0] dofs [4] = '{8'h08, 8'h09, 8'h16, 8'h17};
    logic [7:0] sofs [4] = '{8'h0c, 8'h0d, 8'h1a, 8'h1b};
    pdoe_top u_pdoe_top (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dir_bits(dir_bits),
        .pt_oe(pt_oe), .pio_oe(pio_oe), .src_sel(src_sel), .data_out(data_out),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_fast(pad_fast));
    pdoe_pin_model u_pdoe_pin_model (.pad_out(pad_out), .pad_oe(pad_oe), .pin_level(pin_level));
    initial forever #2.5 mclk = ~mclk;
    // hang guard, well above the ~5600 cycles of the run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 10000) begin
            bad_count++;
            wrap_up();
        end
    end
    task note(input bit bad, input string s);
        checked++;
        if (bad) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, s);
        end
    endtask
    task cmp_pad(input logic [7:0] g, input logic [7:0] e);
        note(g !== e, "pad value");
    endtask
    task cmp_rd(input logic [7:0] g, input logic [7:0] e);
        note(g !== e, "read data");
    endtask
    task wrap_up();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // write strobe held one cycle, released after the taking edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        foreach (dofs[p]) if (a == dofs[p]) drv[p] = d & (odm[p] | slm[p]);
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // data is looked at a full cycle after the read edge; it holds till the next read
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        #1 cmp_rd(reg_rdata, e);
    endtask
    // enable source: product term, repeater on port a only, else direction
    function automatic logic [7:0] exp_oe(input int p);
        logic [1:0] s;
        s = src_sel[p*16+:2];
        if (s == 2'h1) return pt_oe[p*8+:8];
        if (s == 2'h2 && p == 0) return {8{pio_oe}};
        return dir_bits[p*8+:8];
    endfunction
    task check_all();
        logic [7:0] od, oe, eo, ee;
        repeat (3) @(posedge mclk);
        #1;
        for (int p = 0; p < 4; p++) begin
            od = drv[p] & odm[p];
            oe = exp_oe(p);
            eo = data_out[p*8+:8] & ~od;
            ee = oe & ~(od & data_out[p*8+:8]);
            cmp_pad(pad_fast[p*8+:8], drv[p] & slm[p]);
            cmp_pad(pad_out[p*8+:8] & pm[p], eo & pm[p]);
            cmp_pad(pad_oe[p*8+:8] & pm[p], ee & pm[p]);
            cmp_pad(pin_level[p*8+:8] & pm[p], (eo | ~ee) & pm[p]);
            rd(dofs[p], drv[p]);
            rd(sofs[p], oe & pm[p]);
        end
        rd(8'h30, 8'h00);
    endtask
    initial begin
        int k;
        reset <= 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        check_all();
        repeat (150) begin
            @(posedge mclk);
            dir_bits <= $random(seed);
            pt_oe <= $random(seed);
            data_out <= $random(seed);
            pio_oe <= 1'($random(seed));
            for (int i = 0; i < 32; i++) src_sel[2*i+:2] <= 2'($unsigned($random(seed)) % 3);
            k = $unsigned($random(seed)) % 4;
            wr(dofs[k], 8'($random(seed)));
            wr(sofs[k], 8'($random(seed)));
            wr(8'h30, 8'($random(seed)));
            check_all();
        end
        wrap_up();
    end
endmodule // tb_pdoe_top
bind pdoe_top pdoe_top_checker u_pdoe_top_checker (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dir_bits(dir_bits), .pt_oe(pt_oe), .src_sel(src_sel),
    .pad_out(pad_out), .pad_fast(pad_fast));
